// ==== core/serial_nand_feature_regs.sv ====
// Feature and status register set of a serial NAND device
//
// Overview of operation
// [R1] Lock bits frozen when write-protect low, blocker set
// [R2] Three lock bits encode locked range, default all
// [R3] ID-read bit selects parameter/unique ID mode
// [R4] Correction enable bit, default on
// [R5] Protect execute accepted only with protect bit
// [R6] Fast page read bit, default on
// [R7] Pause disable bit turns hold off
// [R8] Host disables pause before quad loads
// [R9] Correction state reports last page read
// [R10] Flip count compared with threshold nibble
// [R11] Program fail bit reflects last program
// [R12] Erase fail bit reflects last erase
// [R13] Write latch reads state, default zero
// [R14] Only enable/disable commands change write latch
// [R15] Busy flag high during internal operation
// [R16] Get-feature repeats the selected byte
// [R17] Busy and fail flags refreshed each byte
// [R18] Fail flags hold until next accepted command
// [R19] Output continues until chip select high
// [R20] Reserved bits read zero
// [R21] Settings survive reset command, power-on defaults
// [R22] Array writes ignored while write latch clear
// [R23] Set-feature: opcode, address, data, commit at end
`timescale 1ns/1ps
`default_nettype none
module serial_nand_feature_regs
  import feat_pkg::*;
(
  // Clock and power-on reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   resetn_i,
  // Byte stream from the serial shifter
  input  wire feat_pkg::frame_in_t    frame_i,
  input  wire logic                   load_byte_i,
  input  wire logic                   write_protect_n_i,
  // Engine status
  input  wire logic                   busy_i,
  input  wire feat_pkg::read_result_t read_res_i,
  input  wire feat_pkg::op_result_t   op_res_i,
  // Readback byte for the shifter
  output logic [7:0]                  tx_byte_o,
  output logic                        tx_active_o,
  // Settings and command grants
  output feat_pkg::settings_t         settings_o,
  output logic                        array_cmd_accept_o,
  output logic                        protect_cmd_accept_o
);

  typedef enum logic [3:0] {
    ST_OPCODE = 4'b0001,
    ST_ADDR   = 4'b0010,
    ST_DATA   = 4'b0100,
    ST_OUTPUT = 4'b1000
  } phase_t;

  typedef enum logic [1:0] {
    KIND_NONE = 2'h0,
    KIND_SET  = 2'h1,
    KIND_GET  = 2'h2
  } kind_t;

  // Whole module state
  typedef struct packed {
    phase_t     phase;
    kind_t      kind;
    logic [7:0] opcode;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wdata_ok;
    logic [7:0] lock_reg;
    logic [7:0] config_reg;
    logic [7:0] thresh_reg;
    logic [1:0] corr_reg;
    logic       pfail_reg;
    logic       efail_reg;
    logic       wel_reg;
    logic [7:0] tx_byte;
    logic       tx_active;
    logic       array_acc;
    logic       prot_acc;
  } state_t;

  state_t     st_reg;
  state_t     st_next;
  logic [1:0] graded;
  logic [7:0] live_byte;
  logic       lock_frozen;
  logic       cmd_taken;

  // Correction grading kept apart so the threshold compare is reusable
  corr_grade u_grade (
    .res_i    (read_res_i),
    .thresh_i (st_reg.thresh_reg[7:THRESH_LO_BIT]),
    .state_o  (graded)
  );

  // Readback mux built from live state each byte
  always_comb begin
    live_byte = 8'h00; // [R20]
    if (st_reg.addr == ADDR_LOCK_RANGE) begin
      live_byte = st_reg.lock_reg & LOCK_MASK;
    end else if (st_reg.addr == ADDR_CONFIG) begin
      live_byte = st_reg.config_reg & CONFIG_MASK;
    end else if (st_reg.addr == ADDR_FLIP_THRESH) begin
      live_byte = st_reg.thresh_reg & THRESH_MASK;
    end else if (st_reg.addr == ADDR_STATUS) begin
      live_byte[ST_CORR_LO_BIT+1:ST_CORR_LO_BIT] = st_reg.corr_reg; // [R9]
      live_byte[ST_PFAIL_BIT] = st_reg.pfail_reg;
      live_byte[ST_EFAIL_BIT] = st_reg.efail_reg;
      live_byte[ST_WEL_BIT]   = st_reg.wel_reg; // [R13]
      live_byte[ST_BUSY_BIT]  = busy_i; // [R15] [R17]
    end
  end

  // Lock field is frozen only with the pin low and the blocker set
  assign lock_frozen = !write_protect_n_i && st_reg.lock_reg[LOCK_WB_BIT]; // [R1]

  // A write command that the device accepts
  assign cmd_taken = frame_i.byte_valid && st_reg.phase == ST_OPCODE &&
                     !busy_i &&
                     (((frame_i.byte_data == CMD_PROG_EXECUTE ||
                        frame_i.byte_data == CMD_BLOCK_ERASE) && st_reg.wel_reg) ||
                      (frame_i.byte_data == CMD_PROTECT_EXEC && st_reg.wel_reg &&
                       st_reg.config_reg[CFG_PROT_BIT]));

  // Next-state logic
  always_comb begin
    st_next           = st_reg;
    st_next.array_acc = 1'b0;
    st_next.prot_acc  = 1'b0;

    // Frame start resets the decoder
    if (frame_i.start) begin
      st_next.phase    = ST_OPCODE;
      st_next.kind     = KIND_NONE;
      st_next.wdata_ok = 1'b0;
    end

    if (frame_i.byte_valid) begin
      case (st_reg.phase)
        ST_OPCODE: begin
          st_next.opcode = frame_i.byte_data;
          st_next.phase  = ST_ADDR;
          if (frame_i.byte_data == CMD_SET_FEATURE) begin
            st_next.kind = KIND_SET;
          end else if (frame_i.byte_data == CMD_GET_FEATURE) begin
            st_next.kind = KIND_GET;
          end else begin
            st_next.kind = KIND_NONE;
          end
          // Latch only moves on its own two commands
          if (frame_i.byte_data == CMD_WRITE_ENABLE) begin // [R14]
            st_next.wel_reg = 1'b1;
          end else if (frame_i.byte_data == CMD_WRITE_DISABLE) begin // [R14]
            st_next.wel_reg = 1'b0;
          end
          // Array writes need the latch; protect also needs its mode bit
          if (cmd_taken) begin // [R22]
            st_next.array_acc = frame_i.byte_data != CMD_PROTECT_EXEC;
            st_next.prot_acc  = frame_i.byte_data == CMD_PROTECT_EXEC; // [R5]
            st_next.pfail_reg = 1'b0; // [R18]
            st_next.efail_reg = 1'b0; // [R18]
          end
        end
        ST_ADDR: begin
          st_next.addr  = frame_i.byte_data;
          st_next.phase = (st_reg.kind == KIND_GET) ? ST_OUTPUT : ST_DATA;
        end
        ST_DATA: begin
          if (st_reg.kind == KIND_SET && !st_reg.wdata_ok) begin // [R23]
            st_next.wdata    = frame_i.byte_data;
            st_next.wdata_ok = 1'b1;
          end
        end
        ST_OUTPUT: begin
          st_next.phase = ST_OUTPUT;
        end
        default: begin
          st_next.phase = ST_OPCODE;
        end
      endcase
    end

    // Repeated byte reload while the get frame lasts
    if (st_reg.phase == ST_OUTPUT && st_reg.kind == KIND_GET) begin
      st_next.tx_active = 1'b1;
      if (load_byte_i) begin // [R16] [R17]
        st_next.tx_byte = live_byte;
      end
    end else if (st_reg.phase == ST_ADDR && st_reg.kind == KIND_GET &&
                 frame_i.byte_valid) begin
      st_next.tx_active = 1'b1;
    end

    // Commit set-feature at frame end; chip select high ends output
    if (frame_i.frame_end) begin // [R19]
      st_next.tx_active = 1'b0;
      st_next.phase     = ST_OPCODE;
      st_next.kind      = KIND_NONE;
      if (st_reg.kind == KIND_SET && st_reg.wdata_ok) begin // [R23]
        if (st_reg.addr == ADDR_LOCK_RANGE && !lock_frozen) begin // [R1]
          st_next.lock_reg = st_reg.wdata & LOCK_MASK; // [R2]
        end else if (st_reg.addr == ADDR_CONFIG) begin
          st_next.config_reg = st_reg.wdata & CONFIG_MASK; // [R3] [R4] [R6] [R7]
        end else if (st_reg.addr == ADDR_FLIP_THRESH) begin
          st_next.thresh_reg = st_reg.wdata & THRESH_MASK; // [R10]
        end
      end
    end

    // Engine results; correction state only valid with correction on
    if (read_res_i.done) begin
      st_next.corr_reg = st_reg.config_reg[CFG_ECC_BIT] ? graded : CORR_NONE; // [R4] [R9]
    end
    if (op_res_i.done) begin
      if (op_res_i.is_erase) begin
        st_next.efail_reg = op_res_i.fail; // [R12]
      end else begin
        st_next.pfail_reg = op_res_i.fail; // [R11]
      end
    end
  end

  // State register; only power-on resets settings, reset commands never do
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      st_reg            <= '0;
      st_reg.phase      <= ST_OPCODE;
      st_reg.kind       <= KIND_NONE;
      st_reg.lock_reg   <= LOCK_RESET; // [R21] [R2]
      st_reg.config_reg <= CONFIG_RESET; // [R21]
      st_reg.thresh_reg <= THRESH_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flip-flops
  assign tx_byte_o                     = st_reg.tx_byte;
  assign tx_active_o                   = st_reg.tx_active;
  assign array_cmd_accept_o            = st_reg.array_acc;
  assign protect_cmd_accept_o          = st_reg.prot_acc;
  assign settings_o.lock_range         = st_reg.lock_reg[LOCK_HI_BIT:LOCK_LO_BIT];
  assign settings_o.id_read_mode_on    = st_reg.config_reg[CFG_ID_BIT];
  assign settings_o.ecc_on             = st_reg.config_reg[CFG_ECC_BIT];
  assign settings_o.protect_mode_on    = st_reg.config_reg[CFG_PROT_BIT];
  assign settings_o.fast_page_read_on  = st_reg.config_reg[CFG_FAST_BIT];
  assign settings_o.pause_disable      = st_reg.config_reg[CFG_PAUSE_BIT];
  assign settings_o.write_enable_latch = st_reg.wel_reg;

  // Checks
  sequence set_lock_frame_s;
    frame_i.frame_end && st_reg.kind == KIND_SET && st_reg.wdata_ok &&
      st_reg.addr == ADDR_LOCK_RANGE;
  endsequence

  frozen_lock_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    set_lock_frame_s and lock_frozen |=> $stable(st_reg.lock_reg)) // [R1]
    else $error("lock field changed while frozen");
  lock_write_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    set_lock_frame_s and !lock_frozen |=> st_reg.lock_reg == $past(st_reg.wdata & LOCK_MASK)) // [R2]
    else $error("lock write not applied");
  wel_only_cmds_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    $changed(st_reg.wel_reg) |-> $past(frame_i.byte_valid && st_reg.phase == ST_OPCODE &&
    (frame_i.byte_data == CMD_WRITE_ENABLE || frame_i.byte_data == CMD_WRITE_DISABLE))) // [R14]
    else $error("write latch changed by other command");
  no_wel_grant_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !st_reg.wel_reg |=> !st_reg.array_acc && !st_reg.prot_acc) // [R22]
    else $error("array command granted without latch");
  prot_grant_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    st_reg.prot_acc |-> $past(st_reg.config_reg[CFG_PROT_BIT])) // [R5]
    else $error("protect granted without mode bit");
  efail_capture_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    op_res_i.done && op_res_i.is_erase |=> st_reg.efail_reg == $past(op_res_i.fail)) // [R12]
    else $error("erase fail not captured");
  pfail_capture_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    op_res_i.done && !op_res_i.is_erase |=> st_reg.pfail_reg == $past(op_res_i.fail)) // [R11]
    else $error("program fail not captured");
  out_end_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    frame_i.frame_end |=> !tx_active_o) // [R19]
    else $error("output continued after frame end");
  reserved_zero_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (st_reg.addr == ADDR_STATUS) && load_byte_i && st_reg.phase == ST_OUTPUT
    |=> tx_byte_o[7:6] == 2'h0) // [R20]
    else $error("reserved status bits nonzero");

  // Get frame steps: address byte, then repeated loads
  sequence get_addr_s;
    frame_i.byte_valid && st_reg.phase == ST_ADDR && st_reg.kind == KIND_GET;
  endsequence

  sequence status_load_s;
    st_reg.addr == ADDR_STATUS && st_reg.phase == ST_OUTPUT &&
      st_reg.kind == KIND_GET && load_byte_i;
  endsequence

  // Set frames to the other writable addresses
  sequence set_cfg_frame_s;
    frame_i.frame_end && st_reg.kind == KIND_SET && st_reg.wdata_ok &&
      st_reg.addr == ADDR_CONFIG;
  endsequence

  sequence set_thr_frame_s;
    frame_i.frame_end && st_reg.kind == KIND_SET && st_reg.wdata_ok &&
      st_reg.addr == ADDR_FLIP_THRESH;
  endsequence

  out_start_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    get_addr_s and !frame_i.frame_end |=> tx_active_o) // [R16]
    else $error("output not started after address");
  status_live_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    status_load_s |=> tx_byte_o[ST_BUSY_BIT] == $past(busy_i)) // [R17]
    else $error("busy bit not refreshed on load");
  wel_set_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    frame_i.byte_valid && st_reg.phase == ST_OPCODE &&
    frame_i.byte_data == CMD_WRITE_ENABLE |=> st_reg.wel_reg) // [R13]
    else $error("write enable did not set latch");
  wel_clear_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    frame_i.byte_valid && st_reg.phase == ST_OPCODE &&
    frame_i.byte_data == CMD_WRITE_DISABLE |=> !st_reg.wel_reg) // [R14]
    else $error("write disable did not clear latch");
  config_write_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    set_cfg_frame_s |=> st_reg.config_reg == $past(st_reg.wdata & CONFIG_MASK)) // [R3]
    else $error("config write not applied");
  thresh_write_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    set_thr_frame_s |=> st_reg.thresh_reg == $past(st_reg.wdata & THRESH_MASK)) // [R10]
    else $error("threshold write not applied");
  corr_off_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    read_res_i.done && !st_reg.config_reg[CFG_ECC_BIT] |=> st_reg.corr_reg == CORR_NONE) // [R4]
    else $error("correction state set while correction off");
  corr_capture_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    read_res_i.done && st_reg.config_reg[CFG_ECC_BIT] |=> st_reg.corr_reg == $past(graded)) // [R9]
    else $error("correction state not captured");
  busy_no_grant_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    busy_i |=> !array_cmd_accept_o && !protect_cmd_accept_o) // [R22]
    else $error("command granted while busy");

endmodule
`default_nettype wire

// ==== core/feat_pkg.sv ====
// Package: feature register offsets, layouts, resets and command codes
package feat_pkg;

  // Feature addresses
  localparam logic [7:0] ADDR_LOCK_RANGE   = 8'ha0;
  localparam logic [7:0] ADDR_CONFIG       = 8'hb0;
  localparam logic [7:0] ADDR_STATUS       = 8'hc0;
  localparam logic [7:0] ADDR_FLIP_THRESH  = 8'h10;

  // Command opcodes
  localparam logic [7:0] CMD_SET_FEATURE   = 8'h1f;
  localparam logic [7:0] CMD_GET_FEATURE   = 8'h0f;
  localparam logic [7:0] CMD_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_PROG_EXECUTE  = 8'h10;
  localparam logic [7:0] CMD_PROTECT_EXEC  = 8'h2a;
  localparam logic [7:0] CMD_BLOCK_ERASE   = 8'hd8;

  // Lock range field positions
  localparam int LOCK_WB_BIT = 7;
  localparam int LOCK_HI_BIT = 5;
  localparam int LOCK_LO_BIT = 3;
  // Config field positions
  localparam int CFG_ID_BIT    = 6;
  localparam int CFG_ECC_BIT   = 4;
  localparam int CFG_PROT_BIT  = 2;
  localparam int CFG_FAST_BIT  = 1;
  localparam int CFG_PAUSE_BIT = 0;
  // Status field positions
  localparam int ST_CORR_LO_BIT = 4;
  localparam int ST_PFAIL_BIT   = 3;
  localparam int ST_EFAIL_BIT   = 2;
  localparam int ST_WEL_BIT     = 1;
  localparam int ST_BUSY_BIT    = 0;
  localparam int THRESH_LO_BIT  = 4;

  // Writable masks; reserved bits stay zero
  localparam logic [7:0] LOCK_MASK   = 8'hb8;
  localparam logic [7:0] CONFIG_MASK = 8'h57;
  localparam logic [7:0] THRESH_MASK = 8'hf0;

  // Power-on values
  localparam logic [7:0] LOCK_RESET   = 8'h38;
  localparam logic [7:0] CONFIG_RESET = 8'h12;
  localparam logic [7:0] THRESH_RESET = 8'h00;

  // Correction result encodings
  localparam logic [1:0] CORR_NONE  = 2'h0;
  localparam logic [1:0] CORR_BELOW = 2'h1;
  localparam logic [1:0] CORR_FAIL  = 2'h2;
  localparam logic [1:0] CORR_ABOVE = 2'h3;

  // Byte-level frame from the serial shifter
  typedef struct packed {
    logic       start;
    logic       byte_valid;
    logic [7:0] byte_data;
    logic       frame_end;
  } frame_in_t;

  // Page read result from the read engine
  typedef struct packed {
    logic       done;
    logic       uncorrectable;
    logic [3:0] flip_count;
  } read_result_t;

  // Array operation result from the program/erase engines
  typedef struct packed {
    logic done;
    logic is_erase;
    logic fail;
  } op_result_t;

  // Settings presented to the rest of the device
  typedef struct packed {
    logic [2:0] lock_range;
    logic       id_read_mode_on;
    logic       ecc_on;
    logic       protect_mode_on;
    logic       fast_page_read_on;
    logic       pause_disable;
    logic       write_enable_latch;
  } settings_t;

endpackage

// ==== core/corr_grade.sv ====
// Grades a page read result into the two-bit correction state
`timescale 1ns/1ps
`default_nettype none
module corr_grade
  import feat_pkg::*;
(
  // Read result and threshold
  input  wire feat_pkg::read_result_t res_i,
  input  wire logic [3:0]             thresh_i,
  // Graded state
  output logic [1:0]                  state_o
);
  // Threshold compare against the flip counter nibble
  always_comb begin
    if (res_i.uncorrectable) begin
      state_o = CORR_FAIL;
    end else if (res_i.flip_count == 4'h0) begin
      state_o = CORR_NONE;
    end else if (res_i.flip_count < thresh_i) begin // [R10]
      state_o = CORR_BELOW;
    end else begin
      state_o = CORR_ABOVE;
    end
  end
endmodule
`default_nettype wire

// ==== sim/host_model.sv ====
// Host-side model that issues feature command frames to the register set
`timescale 1ns/1ps
`default_nettype none
module host_model
  import feat_pkg::*;
(
  // Clock
  input  wire logic               clk_sys_i,
  // Readback byte from the device
  input  wire logic [7:0]         tx_byte_i,
  // Frame stream and load requests to the device
  output var  feat_pkg::frame_in_t frame_o,
  output var  logic               load_byte_o
);
  import feat_pkg::*;

  // Idle lines from time zero
  initial begin
    frame_o     = '0;
    load_byte_o = 1'b0;
  end

  // One pulse on the frame lines; idle cycle after keeps pulses distinct
  task automatic drive(input frame_in_t f);
    @(posedge clk_sys_i);
    frame_o <= f;
    @(posedge clk_sys_i);
    frame_o <= '0;
  endtask

  // Chip select falls, then the opcode byte
  task automatic open(input logic [7:0] op);
    drive('{1'b1, 1'b0, 8'h00, 1'b0});
    drive('{1'b0, 1'b1, op, 1'b0});
  endtask

  // One more byte of the frame
  task automatic put(input logic [7:0] b);
    drive('{1'b0, 1'b1, b, 1'b0});
  endtask

  // Chip select rises; wait out the commit before anyone looks
  task automatic close();
    drive('{1'b0, 1'b0, 8'h00, 1'b1});
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask

  // Ask for one readback byte, take it once registered
  task automatic load_one(output logic [7:0] rd);
    @(posedge clk_sys_i);
    load_byte_o <= 1'b1;
    @(posedge clk_sys_i);
    load_byte_o <= 1'b0;
    #1;
    rd = tx_byte_i;
  endtask

  // Whole command of n bytes; quad loads are never issued by this host
  task automatic cmd(input logic [7:0] op, input logic [7:0] ad, input logic [7:0] dt,
                     input int n);
    open(op);
    if (n > 1) put(ad);
    if (n > 2) put(dt);
    close();
  endtask
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench for the feature and status register set
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import feat_pkg::*;

  logic         clk_sys_i, resetn_i, write_protect_n_i, busy_i, load_byte_i;
  logic         tx_active_o, array_cmd_accept_o, protect_cmd_accept_o;
  logic [7:0]   tx_byte_o, rd;
  logic [15:0]  seed;
  read_result_t read_res_i;
  op_result_t   op_res_i;
  frame_in_t    frame_i;
  settings_t    settings_o;
  int           n_mismatch, n_checks, n_arr, n_prot;
  int           m_lock, m_cfg, m_wel, m_pf, m_ef, m_corr, m_thr;

  serial_nand_feature_regs dut_u (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .frame_i(frame_i),
    .load_byte_i(load_byte_i), .write_protect_n_i(write_protect_n_i),
    .busy_i(busy_i), .read_res_i(read_res_i), .op_res_i(op_res_i),
    .tx_byte_o(tx_byte_o), .tx_active_o(tx_active_o), .settings_o(settings_o),
    .array_cmd_accept_o(array_cmd_accept_o), .protect_cmd_accept_o(protect_cmd_accept_o)
  );
  host_model host_u (
    .clk_sys_i(clk_sys_i), .tx_byte_i(tx_byte_o), .frame_o(frame_i),
    .load_byte_o(load_byte_i)
  );

  // 100 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // Grant pulses are one cycle wide, so count them rather than poll
  always @(posedge clk_sys_i) begin
    if (array_cmd_accept_o === 1'b1) n_arr++;
    if (protect_cmd_accept_o === 1'b1) n_prot++;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Expected status byte; busy is whatever the bench drives now
  function automatic int st_exp();
    return (m_corr << 4) | (m_pf << 3) | (m_ef << 2) | (m_wel << 1) | int'(busy_i);
  endfunction

  function automatic logic [8:0] set_exp();
    return {3'(m_lock >> 3), m_cfg[6], m_cfg[4], m_cfg[2:0], m_wel[0]};
  endfunction

  task automatic chk(input logic [8:0] got, input int exp);
    n_checks++;
    if (got !== 9'(exp)) begin
      n_mismatch++;
      $display("unexpected at %0t: check %0d got %h want %h", $time, n_checks, got, 9'(exp));
    end
  endtask

  // Get-feature with one byte taken
  task automatic rdchk(input logic [7:0] ad, input int exp);
    host_u.open(CMD_GET_FEATURE);
    host_u.put(ad);
    host_u.load_one(rd);
    chk(9'(rd), exp);
    host_u.close();
  endtask

  task automatic op_pulse(input logic e, input logic f);
    @(posedge clk_sys_i);
    op_res_i <= '{1'b1, e, f};
    @(posedge clk_sys_i);
    op_res_i <= '0;
  endtask

  task automatic rd_pulse(input logic u, input logic [3:0] f);
    @(posedge clk_sys_i);
    read_res_i <= '{1'b1, u, f};
    @(posedge clk_sys_i);
    read_res_i <= '0;
  endtask

  task automatic defaults();
    m_lock = 8'h38; m_cfg = 8'h12; m_wel = 0; m_pf = 0; m_ef = 0; m_corr = 0; m_thr = 0;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // A hang counts as a failure
  initial begin
    #200000;
    n_mismatch++;
    close_out();
  end

  initial begin
    resetn_i = 1'b0; write_protect_n_i = 1'b1; busy_i = 1'b0;
    read_res_i = '0; op_res_i = '0; seed = 16'h6f8b;
    defaults();
    repeat (2) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    rdchk(ADDR_LOCK_RANGE, 8'h38);
    rdchk(ADDR_CONFIG, 8'h12);
    rdchk(ADDR_STATUS, 8'h00);
    rdchk(ADDR_FLIP_THRESH, 8'h00);
    chk(settings_o, set_exp());
    $display("test reset values done");
    // Random config bytes, reserved bits must drop
    repeat (4) begin
      seed = lfsr(seed);
      host_u.cmd(CMD_SET_FEATURE, ADDR_CONFIG, seed[7:0], 3);
      m_cfg = seed[7:0] & CONFIG_MASK;
      rdchk(ADDR_CONFIG, m_cfg);
      chk(settings_o, set_exp());
    end
    host_u.cmd(CMD_SET_FEATURE, ADDR_CONFIG, 8'hff, 2);
    host_u.cmd(8'hff, 8'h00, 8'h00, 1);
    rdchk(ADDR_CONFIG, m_cfg);
    $display("test config done");
    // Latch moves only by enable and disable
    host_u.cmd(CMD_SET_FEATURE, ADDR_STATUS, 8'hff, 3);
    rdchk(ADDR_STATUS, st_exp());
    host_u.cmd(CMD_WRITE_ENABLE, 8'h00, 8'h00, 1);
    m_wel = 1;
    host_u.cmd(CMD_SET_FEATURE, ADDR_STATUS, 8'h00, 3);
    rdchk(ADDR_STATUS, st_exp());
    chk(settings_o, set_exp());
    host_u.cmd(CMD_WRITE_DISABLE, 8'h00, 8'h00, 1);
    m_wel = 0;
    rdchk(ADDR_STATUS, st_exp());
    $display("test latch done");
    // Every lock code, then the write blocker
    for (int i = 0; i < 8; i++) begin
      host_u.cmd(CMD_SET_FEATURE, ADDR_LOCK_RANGE, 8'(i << 3) | 8'h47, 3);
      m_lock = i << 3;
      chk(settings_o, set_exp());
    end
    rdchk(ADDR_LOCK_RANGE, m_lock);
    write_protect_n_i <= 1'b0;
    host_u.cmd(CMD_SET_FEATURE, ADDR_LOCK_RANGE, 8'h80, 3);
    m_lock = 8'h80;
    host_u.cmd(CMD_SET_FEATURE, ADDR_LOCK_RANGE, 8'h38, 3);
    rdchk(ADDR_LOCK_RANGE, m_lock);
    write_protect_n_i <= 1'b1;
    host_u.cmd(CMD_SET_FEATURE, ADDR_LOCK_RANGE, 8'h28, 3);
    m_lock = 8'h28;
    rdchk(ADDR_LOCK_RANGE, m_lock);
    $display("test lock done");
    // Grants, fail flags and their lifetime
    host_u.cmd(CMD_SET_FEATURE, ADDR_CONFIG, 8'h12, 3);
    m_cfg = 8'h12;
    host_u.cmd(CMD_PROG_EXECUTE, 8'h00, 8'h00, 1);
    chk(9'(n_arr), 0);
    host_u.cmd(CMD_WRITE_ENABLE, 8'h00, 8'h00, 1);
    m_wel = 1;
    host_u.cmd(CMD_PROG_EXECUTE, 8'h00, 8'h00, 1);
    chk(9'(n_arr), 1);
    op_pulse(1'b0, 1'b1);
    m_pf = 1;
    host_u.cmd(CMD_PROTECT_EXEC, 8'h00, 8'h00, 1);
    chk(9'(n_prot), 0);
    rdchk(ADDR_STATUS, st_exp());
    host_u.cmd(CMD_BLOCK_ERASE, 8'h00, 8'h00, 1);
    m_pf = 0;
    chk(9'(n_arr), 2);
    op_pulse(1'b1, 1'b1);
    m_ef = 1;
    rdchk(ADDR_STATUS, st_exp());
    busy_i <= 1'b1;
    host_u.cmd(CMD_PROG_EXECUTE, 8'h00, 8'h00, 1);
    chk(9'(n_arr), 2);
    busy_i <= 1'b0;
    host_u.cmd(CMD_SET_FEATURE, ADDR_CONFIG, 8'h16, 3);
    m_cfg = 8'h16;
    host_u.cmd(CMD_PROTECT_EXEC, 8'h00, 8'h00, 1);
    chk(9'(n_prot), 1);
    op_pulse(1'b0, 1'b0);
    m_ef = 0;
    rdchk(ADDR_STATUS, st_exp());
    $display("test grants done");
    // Continuous readback with busy changing per byte
    host_u.open(CMD_GET_FEATURE);
    host_u.put(ADDR_STATUS);
    for (int i = 0; i < 3; i++) begin
      busy_i <= ~i[0];
      host_u.load_one(rd);
      chk(9'(rd), st_exp());
    end
    chk(9'(tx_active_o), 1);
    host_u.close();
    chk(9'(tx_active_o), 0);
    busy_i <= 1'b0;
    $display("test readback done");
    // Correction grading around the threshold
    host_u.cmd(CMD_SET_FEATURE, ADDR_FLIP_THRESH, 8'h3f, 3);
    m_thr = 3;
    rdchk(ADDR_FLIP_THRESH, 8'h30);
    for (int i = 0; i < 6; i++) begin
      rd_pulse(i == 5, 4'(i));
      m_corr = (i == 5) ? 2 : (i == 0) ? 0 : (i < m_thr) ? 1 : 3;
      rdchk(ADDR_STATUS, st_exp());
    end
    host_u.cmd(CMD_SET_FEATURE, ADDR_CONFIG, 8'h02, 3);
    m_cfg = 8'h02;
    rd_pulse(1'b0, 4'h2);
    m_corr = 0;
    rdchk(ADDR_STATUS, st_exp());
    $display("test correction done");
    // Power-on reset restores defaults
    @(posedge clk_sys_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    defaults();
    rdchk(ADDR_CONFIG, 8'h12);
    rdchk(ADDR_LOCK_RANGE, 8'h38);
    $display("test power-on done");
    close_out();
  end
endmodule
`default_nettype wire
